// [design/raster_timing.sv]
// Raster timing and viewport logic: coordinate registers, timing registers,
// sync generation and display-memory address selection.
// Assumes a host register port with registered read data and synchronous pins.
`timescale 1ns/1ps
`include "raster_cfg.svh"
module raster_timing #(
  parameter int PIXELS_PER_TICK = 16, // Pixels per pixel group clock
  parameter int TICK_DIV = 4          // System clocks per pixel group clock
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Host register port
  input wire logic [5:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // External restarts, active low
  input wire logic line_reset_in_n_i,
  input wire logic field_reset_in_n_i,
  // Monitor syncs
  output logic line_sync_o,
  output logic field_sync_o,
  // Display-memory fetch
  output logic fetch_o,
  output logic in_window_o,
  output logic [11:0] mem_x_o,
  output logic [11:0] mem_y_o,
  // Frame reload event
  output logic frame_reload_o
);

  // ------------------------------------------------------------
  // Coordinate registers
  // ------------------------------------------------------------
  localparam int NCOORD = 10;
  localparam logic [5:0] COORD_ADR [NCOORD] = '{`ADR_SCR_X_START, `ADR_SCR_Y_START,
    `ADR_SCR_X_TERM, `ADR_SCR_Y_TERM, `ADR_WIN_X_START, `ADR_WIN_Y_START,
    `ADR_WIN_X_END, `ADR_WIN_Y_END, `ADR_WIN_SRC_X, `ADR_WIN_SRC_Y};

  logic [11:0] coord_q [NCOORD]; // Host-visible values
  logic [11:0] shad_q [NCOORD];  // Copies used by the current frame
  logic copy_w;                  // Load copies this cycle
  logic run_q;                   // Timing generation running

  // Host copy and frame copy, one pair per register
  genvar gi;
  generate
    for (gi = 0; gi < NCOORD; gi++) begin : g_coord
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          coord_q[gi] <= `RST_COORD;
        end else if (reg_wr_i && reg_addr_i == COORD_ADR[gi]) begin
          coord_q[gi] <= reg_wdata_i[11:0];
        end
      end
      always_ff @(posedge mclk_i) begin
        if (srst_i) begin
          shad_q[gi] <= `RST_COORD;
        end else if (copy_w) begin
          shad_q[gi] <= coord_q[gi];
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Timing and control registers (write-only)
  // ------------------------------------------------------------
  logic [7:0] line_sync_w_q;       // Line sync width
  logic [6:0] line_scan_delay_q;   // Line scan delay
  logic [7:0] line_active_count_q; // Line active count
  logic [8:0] line_total_count_q;  // Line total count
  logic [9:0] field_sync_w_q;      // Field sync width, half lines
  logic [9:0] field_scan_delay_first_q;
  logic [9:0] field_scan_delay_second_q;
  logic [10:0] field_active_lines_q; // Whole lines
  logic [12:0] field_total_count_q;  // Half lines
  logic [2:0] mode_q;                // Master bits and interlace
  logic vte_q;                       // Timing enable

  // Register writes; only implemented bits are kept
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_sync_w_q <= 8'h00;
      line_scan_delay_q <= 7'h00;
      line_active_count_q <= 8'h00;
      line_total_count_q <= 9'h000;
      field_sync_w_q <= 10'h000;
      field_scan_delay_first_q <= 10'h000;
      field_scan_delay_second_q <= 10'h000;
      field_active_lines_q <= 11'h000;
      field_total_count_q <= 13'h0000;
      mode_q <= `RST_MODE;
      vte_q <= 1'b0;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `ADR_LINE_SYNC: line_sync_w_q <= reg_wdata_i[7:0];
        `ADR_LINE_DELAY: line_scan_delay_q <= reg_wdata_i[6:0];
        `ADR_LINE_ACTIVE: line_active_count_q <= reg_wdata_i[7:0];
        `ADR_LINE_TOTAL: line_total_count_q <= reg_wdata_i[8:0];
        `ADR_FIELD_SYNC: field_sync_w_q <= reg_wdata_i[9:0];
        `ADR_FIELD_DLY_FIRST: field_scan_delay_first_q <= reg_wdata_i[9:0];
        `ADR_FIELD_DLY_SECOND: field_scan_delay_second_q <= reg_wdata_i[9:0];
        `ADR_FIELD_ACTIVE: field_active_lines_q <= reg_wdata_i[10:0];
        `ADR_FIELD_TOTAL: field_total_count_q <= reg_wdata_i[12:0];
        `ADR_VIDEO_MODE: mode_q <= reg_wdata_i[2:0];
        `ADR_TIMING_ENABLE: vte_q <= reg_wdata_i[`BIT_TIMING_EN];
        default: ;
      endcase
    end
  end

  // Read data: coordinates read back, everything else reads zero
  logic [15:0] rdata_d;
  always_comb begin
    rdata_d = 16'h0000;
    for (int i = 0; i < NCOORD; i++) begin
      if (reg_addr_i == COORD_ADR[i]) begin
        rdata_d = {4'h0, coord_q[i]};
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_d;
    end
  end

  // ------------------------------------------------------------
  // Pixel group clock and external restarts
  // ------------------------------------------------------------
  logic tick_w;        // One pixel group clock
  logic lrst_prev_q;   // Previous line reset level
  logic frst_prev_q;   // Previous field reset level
  logic lrst_fall_w;
  logic frst_fall_w;

  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .tick_o(tick_w)
  );

  // Falling edges of the active-low restart inputs
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      lrst_prev_q <= 1'b1;
      frst_prev_q <= 1'b1;
    end else begin
      lrst_prev_q <= line_reset_in_n_i;
      frst_prev_q <= field_reset_in_n_i;
    end
  end
  assign lrst_fall_w = lrst_prev_q && !line_reset_in_n_i;
  assign frst_fall_w = frst_prev_q && !field_reset_in_n_i;

  // ------------------------------------------------------------
  // Horizontal and vertical axes
  // ------------------------------------------------------------
  raster_pkg::axis_cfg_t h_cfg;
  raster_pkg::axis_cfg_t v_cfg;
  raster_pkg::axis_out_t h_st;
  raster_pkg::axis_out_t v_st;
  logic field_first_q;   // First field of a frame
  logic [13:0] line_len_q; // Measured line length
  logic [13:0] half_w;     // Half-line point
  logic vstep_w;           // One half line elapsed
  logic interlace_w;

  assign interlace_w = mode_q[`BIT_INTERLACE];
  assign h_cfg = '{14'(line_sync_w_q), 14'(line_scan_delay_q), 14'(line_active_count_q),
    14'(line_total_count_q)};
  // Active lines doubled into half lines; second delay only in interlace
  assign v_cfg = '{14'(field_sync_w_q),
    (field_first_q ? 14'(field_scan_delay_first_q) : 14'(field_scan_delay_second_q)),
    {2'b00, field_active_lines_q, 1'b0}, 14'(field_total_count_q)};

  raster_axis u_line (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .step_i(tick_w),
    .run_i(run_q),
    .master_i(mode_q[`BIT_LINE_MASTER]),
    .restart_i(lrst_fall_w),
    .cfg_i(h_cfg),
    .out_o(h_st)
  );

  raster_axis u_field (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .step_i(vstep_w),
    .run_i(run_q),
    .master_i(mode_q[`BIT_FIELD_MASTER]),
    .restart_i(frst_fall_w),
    .cfg_i(v_cfg),
    .out_o(v_st)
  );

  // Line length, measured so a line slave still finds its half-line point
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_len_q <= `RST_TIMING;
    end else if (h_st.wrap) begin
      line_len_q <= h_st.cnt + 14'h0001;
    end
  end
  assign half_w = mode_q[`BIT_LINE_MASTER] ? {1'b0, h_cfg.total[13:1]} : {1'b0, line_len_q[13:1]};
  assign vstep_w = h_st.wrap || (tick_w && h_st.cnt == half_w - 14'h0001);

  // Field parity: alternates only when interlaced
  always_ff @(posedge mclk_i) begin
    if (srst_i || !run_q || !interlace_w) begin
      field_first_q <= 1'b1;
    end else if (v_st.wrap) begin
      field_first_q <= !field_first_q;
    end
  end

  // ------------------------------------------------------------
  // Run control and frame reload
  // ------------------------------------------------------------
  // Starts at once on enable; on disable runs on to the frame end
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      run_q <= 1'b0;
    end else if (!run_q && vte_q) begin
      run_q <= 1'b1;
    end else if (run_q && !vte_q && v_st.wrap && (!interlace_w || !field_first_q)) begin
      run_q <= 1'b0;
    end
  end

  assign copy_w = v_st.wrap || (!run_q && vte_q);

  // Event registered from copy_w, in the cycle the loaded copies first appear
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      frame_reload_o <= 1'b0;
    end else begin
      frame_reload_o <= copy_w;
    end
  end

  // ------------------------------------------------------------
  // Screen and window address selection
  // ------------------------------------------------------------
  logic [13:0] hoff_w; // Units into active line
  logic [13:0] voff_w; // Half lines into active field
  logic [11:0] x_w;    // Screen position in display memory
  logic [11:0] y_w;
  logic win_w;         // Position inside the window
  logic vis_w;         // Position inside the screen rectangle

  assign hoff_w = h_st.cnt - h_cfg.delay;
  assign voff_w = v_st.cnt - v_cfg.delay;
  assign x_w = shad_q[0] + 12'(12'(hoff_w) * 12'(PIXELS_PER_TICK));
  assign y_w = shad_q[1] + 12'(voff_w[13:1]);
  assign vis_w = (x_w < shad_q[2]) && (y_w < shad_q[3]);
  assign win_w = (x_w >= shad_q[4]) && (x_w < shad_q[6]) && (y_w >= shad_q[5]) && (y_w < shad_q[7]);

  // Registered fetch address; window redirects to its source corner
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      fetch_o <= 1'b0;
      in_window_o <= 1'b0;
      mem_x_o <= `RST_COORD;
      mem_y_o <= `RST_COORD;
    end else begin
      fetch_o <= run_q && !h_st.blank && !v_st.blank && vis_w;
      in_window_o <= win_w;
      mem_x_o <= win_w ? shad_q[8] + (x_w - shad_q[4]) : x_w;
      mem_y_o <= win_w ? shad_q[9] + (y_w - shad_q[5]) : y_w;
    end
  end

  // ------------------------------------------------------------
  // Sync outputs; blanking never leaves the block
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      line_sync_o <= 1'b0;
      field_sync_o <= 1'b0;
    end else begin
      line_sync_o <= h_st.sync;
      field_sync_o <= v_st.sync;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [11:0] wlow_w;
  assign wlow_w = reg_wdata_i[11:0];

  chk_timing_reads_zero: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_rd_i && reg_addr_i == `ADR_LINE_TOTAL |=> reg_rdata_o == 16'h0000)
    else $error("timing register read returned nonzero");

  chk_coord_readback: assert property (@(posedge mclk_i) disable iff (srst_i)
    reg_wr_i && reg_addr_i == `ADR_WIN_SRC_X ##1 !reg_wr_i
    ##1 reg_rd_i && !reg_wr_i && reg_addr_i == `ADR_WIN_SRC_X
    |=> reg_rdata_o == {4'h0, $past(wlow_w, 3)})
    else $error("window source read back differs from write");

  chk_reload_event: assert property (@(posedge mclk_i) disable iff (srst_i)
    run_q && v_st.wrap |=> frame_reload_o && shad_q[0] == $past(coord_q[0]))
    else $error("reload event missing after frame copy");

  chk_idle_no_sync: assert property (@(posedge mclk_i) disable iff (srst_i)
    !run_q ##1 !run_q |-> !line_sync_o && !field_sync_o && !fetch_o)
    else $error("sync or fetch while timing stopped");

  chk_run_to_frame_end: assert property (@(posedge mclk_i) disable iff (srst_i)
    run_q && !v_st.wrap |=> run_q)
    else $error("timing stopped before frame end");

  chk_slave_ignores_total: assert property (@(posedge mclk_i) disable iff (srst_i)
    run_q && !mode_q[`BIT_LINE_MASTER] && !lrst_fall_w && tick_w && h_st.cnt != 14'h3FFF
    |=> h_st.cnt == $past(h_st.cnt) + 14'h0001)
    else $error("line slave wrapped without external reset");

  chk_first_delay_only: assert property (@(posedge mclk_i) disable iff (srst_i)
    !interlace_w ##1 !interlace_w |-> field_first_q)
    else $error("second field delay used while not interlaced");

  chk_window_source: assert property (@(posedge mclk_i) disable iff (srst_i)
    win_w && x_w == shad_q[4] && $stable(shad_q[8]) |=> in_window_o && mem_x_o == $past(shad_q[8]))
    else $error("window corner not fetched from source corner");

  chk_sync_width: assert property (@(posedge mclk_i) disable iff (srst_i)
    run_q && h_st.cnt < h_cfg.sync_w |=> line_sync_o)
    else $error("line sync dropped inside sync width");
endmodule

// [design/raster_cfg.svh]
// Register map, field positions and reset values of the raster timing block.
// Assumes a 6-bit register address and a 16-bit host data path.
`ifndef RASTER_CFG_SVH
`define RASTER_CFG_SVH

// ------------------------------------------------------------
// Readable screen and window coordinate registers
// ------------------------------------------------------------
`define ADR_SCR_X_START 6'h01
`define ADR_SCR_Y_START 6'h02
`define ADR_SCR_X_TERM 6'h03
`define ADR_SCR_Y_TERM 6'h04
`define ADR_WIN_X_START 6'h0E
`define ADR_WIN_Y_START 6'h0F
`define ADR_WIN_X_END 6'h10
`define ADR_WIN_Y_END 6'h11
`define ADR_WIN_SRC_X 6'h12
`define ADR_WIN_SRC_Y 6'h13

// ------------------------------------------------------------
// Write-only timing and control registers
// ------------------------------------------------------------
`define ADR_LINE_SYNC 6'h05
`define ADR_LINE_DELAY 6'h06
`define ADR_LINE_ACTIVE 6'h07
`define ADR_LINE_TOTAL 6'h08
`define ADR_FIELD_SYNC 6'h09
`define ADR_FIELD_DLY_FIRST 6'h0A
`define ADR_FIELD_DLY_SECOND 6'h0B
`define ADR_FIELD_ACTIVE 6'h0C
`define ADR_FIELD_TOTAL 6'h0D
`define ADR_VIDEO_MODE 6'h16
`define ADR_TIMING_ENABLE 6'h1C

// ------------------------------------------------------------
// Mode and enable bit positions
// ------------------------------------------------------------
`define BIT_LINE_MASTER 0
`define BIT_FIELD_MASTER 1
`define BIT_INTERLACE 2
`define BIT_TIMING_EN 0

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RST_COORD 12'h000
`define RST_TIMING 14'h0000
`define RST_MODE 3'h3

`endif

// [design/raster_pkg.sv]
// Types shared by the raster timing block and its axis counters.
// Assumes raster_cfg.svh for addresses and reset values.
package raster_pkg;

  // ------------------------------------------------------------
  // Axis settings and axis state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [13:0] sync_w; // Sync width in units
    logic [13:0] delay;  // Units from sync start to end of blanking
    logic [13:0] active; // Active units
    logic [13:0] total;  // Period in units (master only)
  } axis_cfg_t;

  typedef struct packed {
    logic sync;        // Sync asserted
    logic blank;       // Blanking asserted
    logic wrap;        // Period restarts this cycle
    logic [13:0] cnt;  // Position in units
  } axis_out_t;

endpackage

// [design/tick_divider.sv]
// Divider that makes the one-cycle pixel group clock enable.
// Assumes a single system clock and synchronous reset.
`timescale 1ns/1ps
module tick_divider #(
  parameter int DIV = 4
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Enable pulse
  output logic tick_o
);
  logic [7:0] cnt_q; // Cycles since last tick

  // Count up DIV cycles per tick
  always_ff @(posedge mclk_i) begin
    if (srst_i || cnt_q == 8'(DIV - 1)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign tick_o = !srst_i && (cnt_q == 8'(DIV - 1));
endmodule

// [design/raster_axis.sv]
// One timing axis: counts units, makes sync and blanking, wraps on total
// or on an external restart. Assumes settings stay steady while running.
`timescale 1ns/1ps
`include "raster_cfg.svh"
module raster_axis (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Control
  input wire logic step_i,    // Advance one unit
  input wire logic run_i,     // Timing generation running
  input wire logic master_i,  // Own total governs the period
  input wire logic restart_i, // External restart, slave only
  input raster_pkg::axis_cfg_t cfg_i,
  // State
  output raster_pkg::axis_out_t out_o
);
  logic [13:0] cnt_q; // Unit position
  logic last_w;       // Master end of period
  logic wrap_w;       // Any restart

  assign last_w = master_i && step_i && (cnt_q == cfg_i.total - 14'h0001);
  assign wrap_w = last_w || (!master_i && restart_i);

  // Position counter; a slave ignores its total and follows the restart
  always_ff @(posedge mclk_i) begin
    if (srst_i || !run_i) begin
      cnt_q <= `RST_TIMING;
    end else if (wrap_w) begin
      cnt_q <= `RST_TIMING;
    end else if (step_i && cnt_q != 14'h3FFF) begin
      cnt_q <= cnt_q + 14'h0001;
    end
  end

  // Sync from period start; blanking independent, so sync may outlast it
  assign out_o.cnt = cnt_q;
  assign out_o.wrap = run_i && wrap_w;
  assign out_o.sync = run_i && (cnt_q < cfg_i.sync_w);
  assign out_o.blank = !run_i || (cnt_q < cfg_i.delay) || (cnt_q >= cfg_i.delay + cfg_i.active);
endmodule

// [verif/raster_sync_src.sv]
// Behavioural timing master standing where the monitor and the other processors are.
// Assumes one system clock; makes active-low line and field restart pulses.
`timescale 1ns/1ps
module raster_sync_src #(
  parameter int LINE_CLKS = 60, // Clocks between line restarts
  parameter int LINES = 6,      // Lines between field restarts
  parameter int LOW_CLKS = 2    // Low width, kept below both sync widths
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Control
  input wire logic run_i,
  // Restart pulses, active low
  output logic line_reset_in_n_o,
  output logic field_reset_in_n_o
);
  int clk_cnt; // Position within the line
  int line_cnt; // Line within the field
  // ------------------------------------------------------------
  // Pulse generation; idle level is high
  // ------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i || !run_i) begin
      clk_cnt <= 0;
      line_cnt <= 0;
    end else begin
      clk_cnt <= (clk_cnt == LINE_CLKS - 1) ? 0 : clk_cnt + 1;
      if (clk_cnt == LINE_CLKS - 1) begin
        line_cnt <= (line_cnt == LINES - 1) ? 0 : line_cnt + 1;
      end
    end
  end
  // Short pulses so the device's own sync widths outlast them
  assign line_reset_in_n_o = !(run_i && clk_cnt < LOW_CLKS);
  assign field_reset_in_n_o = !(run_i && clk_cnt < LOW_CLKS && line_cnt == 0);
endmodule

// [verif/tb_raster_timing.sv]
// Self-checking bench for the raster timing block with a restart source beside it.
// Assumes raster_cfg.svh on the include path and TICK_DIV of 4.
`timescale 1ns/1ps
`include "raster_cfg.svh"
module tb_raster_timing;
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0, ls_d = 1'b0, src_run = 1'b0;
  logic [5:0] addr = 6'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic lrst_n, frst_n, lsync, fsync, fetch, inwin, reload;
  logic [11:0] memx, memy, sx, sy;
  logic [15:0] rd_q[$]; // Expected read data
  logic [31:0] ln_q[$]; // Expected {sync width, period}; width 0 skips
  int seed = 32'hB4E2, fail_count = 0, checked = 0, cyc = 0, last_rise = 0, hw = 0, n, f;
  logic [5:0] cad[10] = '{`ADR_SCR_X_START, `ADR_SCR_Y_START, `ADR_SCR_X_TERM, `ADR_SCR_Y_TERM,
    `ADR_WIN_X_START, `ADR_WIN_Y_START, `ADR_WIN_X_END, `ADR_WIN_Y_END, `ADR_WIN_SRC_X, `ADR_WIN_SRC_Y};
  logic [11:0] cv[10];
  raster_timing #(.PIXELS_PER_TICK(16), .TICK_DIV(4)) raster_timing_i (.mclk_i(clk), .srst_i(rst),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .line_reset_in_n_i(lrst_n), .field_reset_in_n_i(frst_n), .line_sync_o(lsync), .field_sync_o(fsync),
    .fetch_o(fetch), .in_window_o(inwin), .mem_x_o(memx), .mem_y_o(memy), .frame_reload_o(reload));
  raster_sync_src raster_sync_src_i (.mclk_i(clk), .srst_i(rst), .run_i(src_run),
    .line_reset_in_n_o(lrst_n), .field_reset_in_n_o(frst_n));
  // ------------------------------------------------------------
  // Clock, comparison and closing
  // ------------------------------------------------------------
  initial forever #2.5 clk = ~clk;
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ------------------------------------------------------------
  // Host register cycles, one strobe per access
  // ------------------------------------------------------------
  task automatic wr_reg(input logic [5:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [15:0] e);
    rd_q.push_back(e);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk);
  endtask
  // Bounded wait until a selected output is seen high at an edge
  task automatic wait_hi(input int s, input int lim);
    int i;
    i = 0;
    do begin @(posedge clk); i++; end while (!(s == 0 ? reload : s == 1 ? fetch : lsync) && i < lim);
    if (i >= lim) check("wait for output", 32'h0, 32'h1);
  endtask
  // ------------------------------------------------------------
  // Result watcher: read data and line shape
  // ------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_d <= rd;
    ls_d <= lsync;
    hw <= lsync ? (ls_d ? hw + 1 : 1) : hw;
    if (rd_d && rd_q.size() > 0) check("read data", {16'h0, rdata}, {16'h0, rd_q.pop_front()});
    if (lsync && !ls_d) begin
      if (ln_q.size() > 0 && last_rise > 0) begin
        if (ln_q[0][31:16] != 0) check("line sync width", hw, ln_q[0][31:16]);
        check("line period", cyc - last_rise, ln_q.pop_front() & 32'hFFFF);
      end
      last_rise <= cyc;
    end
    if (cyc > 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (cad[i]) rd_reg(cad[i], 16'h0000);
    foreach (cad[i]) begin
      cv[i] = 12'($random(seed));
      wr_reg(cad[i], {4'h0, cv[i]});
    end
    foreach (cad[i]) rd_reg(cad[i], {4'h0, cv[i]});
    wr_reg(cad[8], {4'h0, ~cv[8]});
    rd_reg(cad[8], {4'h0, ~cv[8]});
    wr_reg(`ADR_LINE_ACTIVE, 16'h0004);
    rd_reg(`ADR_LINE_ACTIVE, 16'h0000);
    rd_reg(6'h3F, 16'h0000);
    sx = 12'($random(seed)) & 12'h7F0;
    sy = 12'($random(seed)) & 12'h7FF;
    foreach (cad[i]) cv[i] = i == 0 ? sx : i == 1 ? sy : i == 2 ? sx + 12'h040 : i == 3 ? sy + 12'h002 : 12'hFF0;
    foreach (cad[i]) wr_reg(cad[i], {4'h0, cv[i]});
    // Line 2/1/4/10 ticks, field 2/4/3 half lines, 2 lines, 12 half lines
    wr_reg(`ADR_LINE_SYNC, 16'h0002);
    wr_reg(`ADR_LINE_DELAY, 16'h0001);
    wr_reg(`ADR_LINE_TOTAL, 16'h000A);
    wr_reg(`ADR_FIELD_SYNC, 16'h0002);
    wr_reg(`ADR_FIELD_DLY_FIRST, 16'h0004);
    wr_reg(`ADR_FIELD_DLY_SECOND, 16'h0003);
    wr_reg(`ADR_FIELD_ACTIVE, 16'h0002);
    wr_reg(`ADR_FIELD_TOTAL, 16'h000C);
    wr_reg(`ADR_TIMING_ENABLE, 16'h0001);
    // First field starts off the tick grid, so skip it before timing
    wait_hi(0, 500);
    wait_hi(0, 500);
    n = 0;
    f = 0;
    do begin @(posedge clk); n++; if (fsync) f++; end while (!reload && n < 500);
    check("field period", n, 240);
    check("field sync width", f, 40);
    ln_q.push_back({16'd8, 16'd40});
    ln_q.push_back({16'd8, 16'd40});
    wait_hi(1, 300);
    check("first x", memx, sx);
    check("first y", memy, sy);
    check("sync over active", lsync, 1'b1);
    check("parked window", inwin, 1'b0);
    n = 0;
    do begin @(posedge clk); n++; end while (fetch && n < 100);
    check("active length", n, 16);
    wait_hi(0, 300);
    wr_reg(`ADR_WIN_X_START, {4'h0, sx});
    wr_reg(`ADR_WIN_Y_START, {4'h0, sy});
    wait_hi(0, 300);
    wait_hi(1, 300);
    check("window hit", inwin, 1'b1);
    check("window x", memx, cv[8]);
    check("window y", memy, cv[9]);
    wait_hi(0, 300);
    wr_reg(`ADR_TIMING_ENABLE, 16'h0000);
    wait_hi(2, 45);
    repeat (300) @(posedge clk);
    n = 0;
    repeat (120) begin @(posedge clk); n += lsync + fsync + fetch; end
    check("stopped outputs", n, 0);
    wr_reg(`ADR_VIDEO_MODE, 16'h0000);
    src_run <= 1'b1;
    wr_reg(`ADR_TIMING_ENABLE, 16'h0001);
    // Let two external restarts pass so only whole slave lines are timed
    repeat (130) @(posedge clk);
    repeat (3) ln_q.push_back({16'd0, 16'd60});
    n = 0;
    while (ln_q.size() > 0 && n < 1000) begin @(posedge clk); n++; end
    check("slave lines seen", ln_q.size(), 0);
    tally_and_finish();
  end
endmodule
